// file: rtl/clock_security_reset_flags.sv
// clock guard, backup clock, reset-cause flags and cpu clock prescaler
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
// Functional notes
// - clock guard on or off only from option setting read at reset
// - oscillator source chosen only by the option setting
// - filter blocks spikes, suppresses bad clock, resumes on recovery
// - no main clock for a backup period selects backup clock
// - return to main clock once it works again
// - safe_clock_flag set on backup selection, read clears after recovery
// - guard interrupt when flag, enable set and cpu mask clear
// - safe_clock_irq_en is software-only, 1 enables the interrupt
// - guard interrupt wakes from wait, not halt; wait otherwise no effect
// - halt freezes status, stops guard; interrupt wake resumes config
// - undervolt flag set by low-voltage reset, cleared by zero or watchdog
// - watchdog flag set by watchdog reset, cleared by zero or undervolt
// - flags encode pin, watchdog or low-voltage as last reset
// - prescaler picks cpu clock from two divider bits and slow_select
// - clock_out_en drives cpu clock onto the port pin
// - slow_select enables slow mode, divider bits pick its rate
// - slow mode divides by 4 to 32 instead of 2
module clock_security_reset_flags #(
    parameter int ADDR_W = 12
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              opt_guard_en,
    input  wire logic [2:0]        opt_osc_sel,
    input  wire logic              main_osc_in,
    input  wire logic              wdg_reset_cause,
    input  wire logic              lvd_reset_cause,
    input  wire logic              halt_mode,
    input  wire logic              wait_mode,
    input  wire logic              cpu_irq_mask,
    output logic [2:0]             osc_source_sel,
    output logic                   safe_clock_active,
    output logic                   cpu_clk,
    output logic                   clk_out,
    output logic                   clk_out_oe,
    output logic [3:0]             ext_irq_sense,
    output logic                   clock_guard_irq,
    output logic                   wait_wake,
    output logic                   irq
);

    typedef struct packed {
        logic                             awready;
        logic                             wready;
        logic                             arready;
        logic                             aw_hold;
        logic [7:0]                       aw_idx;
        logic                             aw_ok;
        logic                             w_hold;
        logic [7:0]                       w_data;
        logic                             w_lane0;
        logic                             bvalid;
        logic [1:0]                       bresp;
        logic                             rvalid;
        logic [7:0]                       rdata;
        logic [1:0]                       rresp;
        logic                             osc_s1;
        logic                             osc_s2;
        logic                             osc_s3;
        logic                             optg_s1;
        logic                             optg_s2;
        logic [2:0]                       opts_s1;
        logic [2:0]                       opts_s2;
        logic                             opt_loaded;
        logic                             guard_en;
        logic [2:0]                       osc_sel;
        logic [7:0]                       misc;
        logic                             uv_flag;
        logic                             wdg_flag;
        logic                             irq_en;
        logic                             safe_flag;
        clk_guard_pkg::guard_state_t      gst;
        logic                             filter_on;
        logic [clk_guard_pkg::CNT_W-1:0]  gap_cnt;
        logic [2:0]                       good_cnt;
        logic [clk_guard_pkg::CNT_W-1:0]  safe_cnt;
        logic                             safe_lvl;
        logic [4:0]                       pre_cnt;
        logic                             cpu_clk;
        logic                             clk_out;
        logic                             clk_oe;
        logic [2:0]                       istat;
        logic [2:0]                       imask;
        logic                             irq;
        logic                             guard_irq;
        logic                             wait_wake;
    } state_t;

    localparam logic [clk_guard_pkg::CNT_W-1:0] SAFE_LAST =
        clk_guard_pkg::CNT_W'(clk_guard_pkg::SAFE_CYC - 1);
    localparam logic [clk_guard_pkg::CNT_W-1:0] MIN_GAP =
        clk_guard_pkg::CNT_W'(clk_guard_pkg::MIN_GAP_CYC);
    localparam logic [2:0] GOOD_LAST =
        3'(clk_guard_pkg::RECOVER_EDGES - 1);

    state_t q;
    state_t d;

    // source ticks per half cpu period: normal 1, slow 2/4/8/16
    function automatic logic [4:0] half_div(input logic slow,
                                            input logic [1:0] sel);
        if (!slow)
            half_div = 5'h01;
        else
            half_div = 5'(5'h02 << sel);
    endfunction

    // byte address to register index, flags misaligned or high bits
    function automatic logic [8:0] decode(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] <= 'hFF);
        decode = {ok, 8'(a >> 2)};
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        mapped = (idx == clk_guard_pkg::IDX_MISC) ||
                 (idx == clk_guard_pkg::IDX_STATUS) ||
                 (idx == clk_guard_pkg::IDX_ISTAT) ||
                 (idx == clk_guard_pkg::IDX_IMASK);
    endfunction

    logic [8:0] wdec;
    logic [8:0] rdec;
    logic       rise;
    logic       gap_ok;
    logic       filt_edge;
    logic       src_tick;
    logic       do_wr;
    logic       rd_status;
    logic       safe_set;
    logic       filt_set;
    logic       recov_set;
    logic [2:0] ev;
    logic [4:0] half;

    always_comb begin
        d = q;
        wdec = decode(s_axi_awaddr);
        rdec = decode(s_axi_araddr);
        rise = 1'b0;
        gap_ok = 1'b0;
        filt_edge = 1'b0;
        src_tick = 1'b0;
        do_wr = 1'b0;
        rd_status = 1'b0;
        safe_set = 1'b0;
        filt_set = 1'b0;
        recov_set = 1'b0;
        ev = 3'h0;
        half = half_div(q.misc[clk_guard_pkg::MISC_SLOW],
                        {q.misc[clk_guard_pkg::MISC_DIV_HI],
                         q.misc[clk_guard_pkg::MISC_DIV_LO]});

        // pin samples pass two flops before use
        d.osc_s1 = main_osc_in;
        d.osc_s2 = q.osc_s1;
        d.osc_s3 = q.osc_s2;
        d.optg_s1 = opt_guard_en;
        d.optg_s2 = q.optg_s1;
        d.opts_s1 = opt_osc_sel;
        d.opts_s2 = q.opts_s1;

        if (!q.opt_loaded) begin
            d.opt_loaded = 1'b1;
            d.guard_en = q.optg_s2;
            d.osc_sel = q.opts_s2;
        end

        // ---- bus slave ----
        if (s_axi_bvalid && s_axi_bready)
            d.bvalid = 1'b0;
        if (s_axi_rvalid && s_axi_rready)
            d.rvalid = 1'b0;
        if (s_axi_awvalid && q.awready) begin
            d.aw_hold = 1'b1;
            d.aw_idx = wdec[7:0];
            d.aw_ok = wdec[8] && mapped(wdec[7:0]);
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_hold = 1'b1;
            d.w_data = s_axi_wdata[7:0];
            d.w_lane0 = s_axi_wstrb[0];
        end
        if (q.aw_hold && q.w_hold && !q.bvalid) begin
            d.aw_hold = 1'b0;
            d.w_hold = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = q.aw_ok ? clk_guard_pkg::RESP_OKAY
                              : clk_guard_pkg::RESP_SLVERR;
            do_wr = q.aw_ok && q.w_lane0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rdata = 8'h00;
            d.rresp = clk_guard_pkg::RESP_OKAY;
            if (!(rdec[8] && mapped(rdec[7:0])))
                d.rresp = clk_guard_pkg::RESP_SLVERR;
            else begin
                case (rdec[7:0])
                    clk_guard_pkg::IDX_MISC:
                        d.rdata = q.misc;
                    clk_guard_pkg::IDX_STATUS: begin
                        d.rdata[clk_guard_pkg::ST_UV] = q.uv_flag;
                        d.rdata[clk_guard_pkg::ST_IRQ_EN] = q.irq_en;
                        d.rdata[clk_guard_pkg::ST_SAFE] = q.safe_flag;
                        d.rdata[clk_guard_pkg::ST_WDG] = q.wdg_flag;
                        rd_status = 1'b1;
                    end
                    clk_guard_pkg::IDX_ISTAT:
                        d.rdata = {5'h00, q.istat};
                    clk_guard_pkg::IDX_IMASK:
                        d.rdata = {5'h00, q.imask};
                    default:
                        d.rdata = 8'h00;
                endcase
            end
        end

        // ---- clock filter and guard ----
        rise = q.osc_s2 && !q.osc_s3;
        gap_ok = q.gap_cnt >= MIN_GAP;
        if (!halt_mode) begin
            if (rise)
                d.gap_cnt = '0;
            else if (q.gap_cnt != '1)
                d.gap_cnt = q.gap_cnt + 1'b1;
        end
        if (halt_mode) begin
            // guard and backup oscillator stopped, state kept
            d.safe_lvl = q.safe_lvl;
        end else if (!q.guard_en) begin
            // guard off: raw oscillator drives everything
            d.gst = clk_guard_pkg::G_OFF;
            d.filter_on = 1'b0;
            src_tick = rise;
        end else begin
            if (rise && !gap_ok) begin
                if (!q.filter_on)
                    filt_set = 1'b1;
                d.filter_on = 1'b1;
                d.good_cnt = '0;
            end else if (rise && q.filter_on) begin
                if (q.good_cnt == GOOD_LAST) begin
                    d.filter_on = 1'b0;
                    d.good_cnt = '0;
                end else
                    d.good_cnt = q.good_cnt + 1'b1;
            end
            filt_edge = rise && gap_ok && !q.filter_on;
            case (q.gst)
                clk_guard_pkg::G_SAFE: begin
                    // backup oscillator free runs, toggling its level once per backup period
                    if (q.safe_cnt == SAFE_LAST) begin
                        d.safe_cnt = '0;
                        d.safe_lvl = !q.safe_lvl;
                        src_tick = !q.safe_lvl;
                    end else
                        d.safe_cnt = q.safe_cnt + 1'b1;
                    // switch back once main edges are clean
                    if (filt_edge) begin
                        if (q.good_cnt == GOOD_LAST) begin
                            d.gst = clk_guard_pkg::G_MAIN;
                            d.good_cnt = '0;
                            d.safe_cnt = '0;
                            recov_set = 1'b1;
                        end else
                            d.good_cnt = q.good_cnt + 1'b1;
                    end
                end
                default: begin
                    d.gst = clk_guard_pkg::G_MAIN;
                    src_tick = filt_edge;
                    if (filt_edge)
                        d.safe_cnt = '0;
                    // silent for a whole backup period
                    else if (q.safe_cnt == SAFE_LAST) begin
                        d.gst = clk_guard_pkg::G_SAFE;
                        d.safe_cnt = '0;
                        d.good_cnt = '0;
                        safe_set = 1'b1;
                    end else
                        d.safe_cnt = q.safe_cnt + 1'b1;
                end
            endcase
        end

        // ---- registers ----
        if (do_wr) begin
            case (q.aw_idx)
                clk_guard_pkg::IDX_MISC:
                    d.misc = q.w_data;
                clk_guard_pkg::IDX_STATUS: begin
                    if (!halt_mode) begin
                        d.irq_en = q.w_data[clk_guard_pkg::ST_IRQ_EN];
                        if (!q.w_data[clk_guard_pkg::ST_UV])
                            d.uv_flag = 1'b0;
                        if (!q.w_data[clk_guard_pkg::ST_WDG])
                            d.wdg_flag = 1'b0;
                    end
                end
                clk_guard_pkg::IDX_IMASK:
                    d.imask = q.w_data[2:0];
                default:
                    d.misc = d.misc;
            endcase
        end
        // read clears only after recovery; set wins
        if (rd_status && !halt_mode && q.gst != clk_guard_pkg::G_SAFE)
            d.safe_flag = 1'b0;
        if (safe_set)
            d.safe_flag = 1'b1;

        ev[clk_guard_pkg::EV_SAFE] = safe_set;
        ev[clk_guard_pkg::EV_FILTER] = filt_set;
        ev[clk_guard_pkg::EV_RECOVER] = recov_set;
        if (do_wr && q.aw_idx == clk_guard_pkg::IDX_ISTAT)
            d.istat = q.istat & ~q.w_data[2:0];
        d.istat = d.istat | ev;

        // ---- prescaler and clock out ----
        // divide selected source
        if (src_tick) begin
            if (q.pre_cnt >= half - 5'h01) begin
                d.pre_cnt = 5'h00;
                d.cpu_clk = !q.cpu_clk;
            end else
                d.pre_cnt = q.pre_cnt + 5'h01;
        end
        d.clk_oe = d.misc[clk_guard_pkg::MISC_CLK_OUT];
        d.clk_out = d.clk_oe && d.cpu_clk;

        // gated by enable and cpu mask
        d.guard_irq = d.safe_flag && d.irq_en && !cpu_irq_mask;
        // wait wake; halt never woken here
        d.wait_wake = d.safe_flag && d.irq_en && wait_mode &&
                      !halt_mode;
        d.irq = |(d.istat & d.imask);

        d.awready = !d.aw_hold && !d.bvalid;
        d.wready = !d.w_hold && !d.bvalid;
        d.arready = !d.rvalid;

        if (!aresetn) begin
            d = '0;
            d.gst = clk_guard_pkg::G_MAIN;
            d.misc = clk_guard_pkg::MISC_RESET;
            d.istat = clk_guard_pkg::EV_RESET;
            d.imask = clk_guard_pkg::EV_RESET;
            // option sync runs through reset, else the latch sees zero
            d.optg_s1 = opt_guard_en;
            d.optg_s2 = q.optg_s1;
            d.opts_s1 = opt_osc_sel;
            d.opts_s2 = q.opts_s1;
            d.uv_flag = q.uv_flag;
            d.wdg_flag = q.wdg_flag;
            if (lvd_reset_cause) begin
                d.uv_flag = 1'b1;
                d.wdg_flag = 1'b0;
            end else if (wdg_reset_cause) begin
                d.wdg_flag = 1'b1;
                d.uv_flag = 1'b0;
            end
        end
    end

    // whole state in one register; reset handled in the comb block
    always_ff @(posedge aclk) begin
        q <= d;
    end

    assign s_axi_awready     = q.awready;
    assign s_axi_wready      = q.wready;
    assign s_axi_arready     = q.arready;
    assign s_axi_bvalid      = q.bvalid;
    assign s_axi_bresp       = q.bresp;
    assign s_axi_rvalid      = q.rvalid;
    assign s_axi_rdata       = {24'h000000, q.rdata};
    assign s_axi_rresp       = q.rresp;
    assign osc_source_sel    = q.osc_sel;
    assign safe_clock_active = (q.gst == clk_guard_pkg::G_SAFE);
    assign cpu_clk           = q.cpu_clk;
    assign clk_out           = q.clk_out;
    assign clk_out_oe        = q.clk_oe;
    assign ext_irq_sense     = {q.misc[clk_guard_pkg::MISC_SENSE_B1],
                                q.misc[clk_guard_pkg::MISC_SENSE_B0],
                                q.misc[clk_guard_pkg::MISC_SENSE_A1],
                                q.misc[clk_guard_pkg::MISC_SENSE_A0]};
    assign clock_guard_irq   = q.guard_irq;
    assign wait_wake         = q.wait_wake;
    assign irq               = q.irq;

endmodule // clock_security_reset_flags

// file: rtl/clk_guard_pkg.sv
// constants for the clock supervision and reset-cause block
package clk_guard_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_MISC   = 8'h20;
    localparam logic [7:0] IDX_STATUS = 8'h25;
    localparam logic [7:0] IDX_ISTAT  = 8'h26;
    localparam logic [7:0] IDX_IMASK  = 8'h27;
    // misc_control_one fields
    localparam int MISC_SLOW     = 0;
    localparam int MISC_DIV_LO   = 1;
    localparam int MISC_DIV_HI   = 2;
    localparam int MISC_SENSE_A0 = 3;
    localparam int MISC_SENSE_A1 = 4;
    localparam int MISC_CLK_OUT  = 5;
    localparam int MISC_SENSE_B0 = 6;
    localparam int MISC_SENSE_B1 = 7;
    localparam logic [7:0] MISC_RESET = 8'h00;
    // reset_clock_status fields
    localparam int ST_WDG     = 0;
    localparam int ST_SAFE    = 1;
    localparam int ST_IRQ_EN  = 2;
    localparam int ST_UV      = 4;
    // interrupt status / mask fields
    localparam int EV_SAFE    = 0;
    localparam int EV_FILTER  = 1;
    localparam int EV_RECOVER = 2;
    localparam logic [2:0] EV_RESET = 3'h0;
    // timing
    localparam int CLK_PERIOD_NS  = 40;
    localparam int SAFE_PERIOD_NS = 4000;
    localparam int MIN_GAP_NS     = 80;
    localparam int SAFE_CYC = SAFE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int MIN_GAP_CYC =
        (MIN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_EDGES = 4;
    localparam int CNT_W = 8;
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        G_MAIN = 2'b00,
        G_SAFE = 2'b01,
        G_OFF  = 2'b10
    } guard_state_t;
endpackage

// file: tb/osc_partner.sv
// main oscillator model: steady toggle or stopped
`timescale 1ns/1ns
module osc_partner (
    input  logic       aclk,
    input  logic [7:0] half,
    output logic       main_osc_in
);
    logic [7:0] cnt_q;
    initial begin
        cnt_q = 8'h00;
        main_osc_in = 1'h0;
    end
    // half of zero stops it; a dead crystal just holds its level
    always @(posedge aclk) begin
        if (half == 8'h00) begin
            cnt_q <= 8'h00;
        end else if (cnt_q + 8'h01 >= half) begin
            cnt_q <= 8'h00;
            main_osc_in <= ~main_osc_in;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // osc_partner

// file: tb/clock_security_reset_flags_asserts.sv
// port assertions for the clock guard block
`timescale 1ns/1ns
module clock_security_reset_flags_asserts (
    input logic        aclk,
    input logic        aresetn,
    input logic        cpu_irq_mask,
    input logic        wait_mode,
    input logic        halt_mode,
    input logic        wait_wake,
    input logic        clock_guard_irq,
    input logic        clk_out,
    input logic        clk_out_oe,
    input logic [2:0]  osc_source_sel,
    input logic        safe_clock_active,
    input logic        cpu_clk,
    input logic        irq,
    input logic        s_axi_rvalid,
    input logic [31:0] s_axi_rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_irq_mask; clock_guard_irq |-> !$past(cpu_irq_mask); endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("guard irq while cpu mask set");
    property p_wake; wait_wake |-> $past(wait_mode) && !$past(halt_mode);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake without wait mode");
    property p_halt_wake; halt_mode [*2] |-> !wait_wake; endproperty
    a_halt_wake: assert property (p_halt_wake)
        else $error("wake from halt");
    property p_clk_out; clk_out == (clk_out_oe && cpu_clk); endproperty
    a_clk_out: assert property (p_clk_out)
        else $error("clock out toggles while disabled");
    // option code is latched once; later edges must not move it
    property p_osc_fixed; $past(aresetn, 3) |-> $stable(osc_source_sel);
    endproperty
    a_osc_fixed: assert property (p_osc_fixed)
        else $error("oscillator select changed at run time");
    property p_freeze;
        halt_mode && $past(halt_mode) |-> $stable(safe_clock_active)
            && $stable(cpu_clk);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved in halt");
    property p_rst; $rose(aresetn) |-> !safe_clock_active && !cpu_clk
        && !clock_guard_irq && !irq; endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not at reset values");
    property p_rdata; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_rdata: assert property (p_rdata)
        else $error("upper read bits not zero");
endmodule // clock_security_reset_flags_asserts

// file: tb/clock_security_reset_flags_test.sv
// self-checking bench for the clock guard block
`timescale 1ns/1ns
module clock_security_reset_flags_test;
    logic        aclk, aresetn, awv, wv, bry, arv, rry, undervolt_detector, wdg;
    logic        halt, wt, msk, awr, wrr, bv, arr, rv, osc, safe, cpu;
    logic        co, coe, gi, ww, irq, og;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdd, rsp;
    logic [7:0]  half, m;
    logic [2:0]  osel;
    logic [3:0]  sense;
    logic [1:0]  br, rr;
    int          error_cnt, compares, cyc, n;
    time         t;
    clock_security_reset_flags clock_security_reset_flags_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .opt_guard_en(og), .opt_osc_sel(3'h5),
        .main_osc_in(osc), .wdg_reset_cause(wdg), .lvd_reset_cause(undervolt_detector),
        .halt_mode(halt), .wait_mode(wt), .cpu_irq_mask(msk),
        .osc_source_sel(osel), .safe_clock_active(safe), .cpu_clk(cpu),
        .clk_out(co), .clk_out_oe(coe), .ext_irq_sense(sense),
        .clock_guard_irq(gi), .wait_wake(ww), .irq(irq));
    osc_partner osc_partner_inst (.aclk(aclk), .half(half),
        .main_osc_in(osc));
    initial begin
        aclk = 1'h0;
        forever #20 aclk = ~aclk;
    end
    task automatic print_verdict;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge aclk);
        awa <= {2'h0, idx, 2'h0};
        wd <= {24'h0, d};
        awv <= 1'h1;
        wv <= 1'h1;
        bry <= 1'h1;
        do begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'h0;
            if (wv && wrr) wv <= 1'h0;
        end while (!bv);
        rsp = {30'h0, br};
        bry <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        @(posedge aclk);
        ara <= {2'h0, idx, 2'h0};
        arv <= 1'h1;
        rry <= 1'h1;
        do begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'h0;
        end while (!rv);
        rsp = {30'h0, rr};
        rry <= 1'h0;
        chk(rdd, exp);
    endtask
    task automatic rst(input logic l, input logic w);
        @(posedge aclk);
        aresetn <= 1'h0;
        undervolt_detector <= l;
        wdg <= w;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        undervolt_detector <= 1'h0;
        wdg <= 1'h0;
        repeat (2) @(posedge aclk);
    endtask
    // hang guard, well above the longest divider sweep
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            print_verdict;
        end
    end
    initial begin
        {aresetn, awv, wv, bry, arv, rry, wdg, halt, wt, msk} = 10'h000;
        undervolt_detector = 1'h1;
        og = 1'h1;
        {awa, ara, wd, half} = 64'h0;
        rst(1'h1, 1'h0);
        rd(clk_guard_pkg::IDX_STATUS, 32'h10); // lvd cause
        chk(osel, 3'h5); // option source
        wr(clk_guard_pkg::IDX_STATUS, 8'hFF);
        rd(clk_guard_pkg::IDX_STATUS, 32'h14); // reserved bits
        rst(1'h0, 1'h1);
        rd(clk_guard_pkg::IDX_STATUS, 32'h01); // watchdog cause
        rst(1'h1, 1'h0);
        rd(clk_guard_pkg::IDX_STATUS, 32'h10); // lvd clears it
        rst(1'h0, 1'h0);
        rd(clk_guard_pkg::IDX_STATUS, 32'h10); // pin keeps flags
        wr(clk_guard_pkg::IDX_STATUS, 8'h00);
        rd(clk_guard_pkg::IDX_STATUS, 32'h00); // software clear
        wr(clk_guard_pkg::IDX_MISC, 8'hFF);
        rd(clk_guard_pkg::IDX_MISC, 32'hFF); // misc readback
        chk(sense, 4'hF);
        chk(coe, 1'h1); // pin driven
        half <= 8'h04;
        for (int i = 0; i < 5; i++) begin
            m = (i == 0) ? 8'h20 : 8'h21 | 8'((i - 1) << 1);
            wr(clk_guard_pkg::IDX_MISC, m);
            repeat (2) @(posedge cpu);
            t = $time;
            @(posedge cpu);
            // oscillator period 8 cycles times divider 2 << i
            chk(32'(($time - t) / 40), 32'(16 << i));
        end
        wr(clk_guard_pkg::IDX_MISC, 8'h00);
        repeat (2) @(posedge aclk);
        chk(coe, 1'h0); // pin released
        wr(clk_guard_pkg::IDX_IMASK, 8'h07);
        wr(clk_guard_pkg::IDX_STATUS, 8'h04);
        half <= 8'h00;
        for (n = 0; n < 300 && safe !== 1'h1; n++) @(posedge aclk);
        chk(32'(n > 90 && safe === 1'h1), 32'h1); // backup taken
        repeat (3) @(posedge aclk);
        chk(gi, 1'h1); // guard irq
        chk(irq, 1'h1);
        rd(clk_guard_pkg::IDX_ISTAT, 32'h01);
        msk <= 1'h1;
        wt <= 1'h1;
        repeat (3) @(posedge aclk);
        chk(gi, 1'h0); // masked
        chk(ww, 1'h1); // wait wake
        halt <= 1'h1;
        repeat (3) @(posedge aclk);
        chk(ww, 1'h0); // no halt wake
        wr(clk_guard_pkg::IDX_STATUS, 8'h00);
        rd(clk_guard_pkg::IDX_STATUS, 32'h06); // frozen in halt
        halt <= 1'h0;
        wt <= 1'h0;
        rd(clk_guard_pkg::IDX_STATUS, 32'h06); // kept on backup
        half <= 8'h04;
        for (n = 0; n < 300 && safe !== 1'h0; n++) @(posedge aclk);
        chk(safe, 1'h0); // switch back
        rd(clk_guard_pkg::IDX_STATUS, 32'h06); // read clears
        rd(clk_guard_pkg::IDX_STATUS, 32'h04); // now clear
        rd(clk_guard_pkg::IDX_ISTAT, 32'h05);
        wr(clk_guard_pkg::IDX_ISTAT, 8'h07);
        repeat (2) @(posedge aclk);
        chk(irq, 1'h0);
        half <= 8'h01;
        repeat (20) @(posedge aclk);
        rd(clk_guard_pkg::IDX_ISTAT, 32'h02); // spikes filtered
        half <= 8'h04;
        repeat (100) @(posedge aclk);
        chk(safe, 1'h0); // clock passes again
        rd(8'h30, 32'h0);
        chk(rsp, 32'(clk_guard_pkg::RESP_SLVERR));
        wr(8'h30, 8'hFF);
        chk(rsp, 32'(clk_guard_pkg::RESP_SLVERR));
        og <= 1'h0;
        half <= 8'h00;
        rst(1'h0, 1'h0);
        repeat (150) @(posedge aclk);
        chk(safe, 1'h0); // guard off by option
        print_verdict;
    end
endmodule // clock_security_reset_flags_test
bind clock_security_reset_flags clock_security_reset_flags_asserts
    clock_security_reset_flags_asserts_inst (.aclk(aclk),
    .aresetn(aresetn), .cpu_irq_mask(cpu_irq_mask), .wait_mode(wait_mode),
    .halt_mode(halt_mode), .wait_wake(wait_wake), .clk_out(clk_out),
    .clock_guard_irq(clock_guard_irq), .clk_out_oe(clk_out_oe),
    .osc_source_sel(osc_source_sel), .safe_clock_active(safe_clock_active),
    .cpu_clk(cpu_clk), .irq(irq), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rdata(s_axi_rdata));
